// ==== rtl/bit_sync2.sv ====
// Two-flop synchroniser for a bundle of asynchronous levels.
// Assumes each bit is an independent level; no bus coherence across bits.
`timescale 1ns/1ps
module bit_sync2 #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // Levels
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } sync_state_t;

  sync_state_t st_r;
  sync_state_t st_nxt;

  // Per-bit two stage chain; first stage feeds only the second
  for (genvar i = 0; i < W; i++) begin : g_bit
    always_comb begin
      st_nxt.meta[i]   = async_in[i];
      st_nxt.stable[i] = st_r.meta[i];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign sync_out = st_r.stable;

endmodule : bit_sync2

// ==== rtl/diag_flag_bank.sv ====
// Sticky diagnostic flag bank.
// Assumes set and clear masks come from logic on the same clock.
`timescale 1ns/1ps
module diag_flag_bank #(
  parameter int W = 8
) (
  // Clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // Events and acknowledge
  input  wire logic [W-1:0] set_mask,
  input  wire logic [W-1:0] clear_mask,
  output logic      [W-1:0] flags
);

  typedef struct packed {
    logic [W-1:0] flags;
  } flag_state_t;

  flag_state_t st_r;
  flag_state_t st_nxt;

  // Set beats clear so an event in the acknowledge cycle survives
  for (genvar i = 0; i < W; i++) begin : g_flag
    always_comb begin
      st_nxt.flags[i] = set_mask[i] | (st_r.flags[i] & ~clear_mask[i]);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign flags = st_r.flags;

endmodule : diag_flag_bank

// ==== rtl/lin_diag_pkg.sv ====
// Shared constants for the LIN I/O slave configuration tail, diagnostics and mode sequencer.
// Assumes a single 25 MHz APB clock; frame-level events come from a LIN controller on that clock.
package lin_diag_pkg;

  // APB register byte offsets
  localparam logic [7:0] OFF_CTRL     = 8'h00;
  localparam logic [7:0] OFF_STATUS   = 8'h04;
  localparam logic [7:0] OFF_FALLBACK = 8'h08;
  localparam logic [7:0] OFF_NODE     = 8'h0c;
  localparam logic [7:0] OFF_LATCH    = 8'h10;

  // Control register field positions
  localparam int CTRL_SLOPE_BIT = 0;
  localparam int CTRL_ECC_BIT   = 1;
  localparam int CTRL_SLEEP_USES_FALLBACK_BIT  = 2;
  localparam int CTRL_INHX_BIT  = 3;

  // Configuration request fields (bit positions inside the fourth byte of the 8-byte frame, D0 in the low byte)
  localparam int CFG_SLOPE_BIT  = 1;
  localparam int CFG_ECC_BIT    = 0;
  localparam logic [1:0] BLK_THIRD  = 2'b10;
  localparam logic [1:0] BLK_FOURTH = 2'b11;

  // Frame byte codes
  localparam logic [7:0] SVC_IO_CONFIG = 8'hb4;
  localparam logic [7:0] RSP_IO_CONFIG = 8'hf4;
  localparam logic [7:0] PCI_DIAG_RSP  = 8'h04;
  localparam logic [7:0] DIAG_CTRL     = 8'hc0;
  localparam logic [7:0] FILL_BYTE     = 8'hff;

  // Diagnostic flag positions
  localparam int FLG_PARITY = 7;
  localparam int FLG_RXB    = 6;
  localparam int FLG_CS     = 5;
  localparam int FLG_TXB    = 4;
  localparam int FLG_NVM    = 2;
  localparam int FLG_LHE    = 1;
  localparam int FLG_ERR    = 0;

  // Reset values
  localparam logic [7:0] RST_NAD      = 8'h7f;
  localparam logic [7:0] RST_FALLBACK = 8'h00;
  localparam logic [7:0] RST_LATCH    = 8'h00;

  // Operating modes, one-hot
  typedef enum logic [5:0] {
    MODE_CONFIG   = 6'b000001,
    MODE_NORMAL   = 6'b000010,
    MODE_SLEEP    = 6'b000100,
    MODE_LH_SLEEP = 6'b001000,
    MODE_LIMP     = 6'b010000,
    MODE_STANDBY  = 6'b100000
  } op_mode_t;

endpackage : lin_diag_pkg

// ==== rtl/lin_slave_config_diag_modes.sv ====
// LIN I/O slave: third configuration block, diagnostic block and mode sequencer, with APB registers.
// Assumes a LIN frame controller on pclk delivering decoded frames and error events as pulses.
//
// Design decisions made here: the APB register port and the register addresses.
`timescale 1ns/1ps
module lin_slave_config_diag_modes
  import lin_diag_pkg::*;
#(
  parameter logic [7:0] DEFAULT_NAD = RST_NAD,  // Arbitrary neutral default address
  parameter int         PINS        = 8
) (
  // APB slave
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Frames to and from the LIN controller
  input  wire logic              req_valid,
  input  wire logic [63:0]       req_data,
  input  wire logic              resp_slot,
  input  wire logic              resp_done,
  output logic                   resp_valid,
  output logic      [63:0]       resp_data,
  // Error and bus events
  input  wire logic              parity_err,
  input  wire logic              receive_frame_fault,
  input  wire logic              checksum_err,
  input  wire logic              transmit_bit_fault,
  input  wire logic              in_response,
  input  wire logic              no_valid_frame_timeout,
  input  wire logic              bus_idle_timeout,
  input  wire logic              bus_dominant_timeout,
  input  wire logic              sleep_cmd,
  input  wire logic              remote_wake,
  input  wire logic              assign_nad,
  input  wire logic [7:0]        assign_nad_value,
  input  wire logic              default_nad_used,
  // Pin output frames
  input  wire logic              io_out_load,
  input  wire logic [PINS-1:0]   io_out_value,
  input  wire logic [PINS-1:0]   io_out_enable,
  // Pins
  input  wire logic              local_wake_pin,
  output logic      [PINS-1:0]   pin_output_register,
  output logic      [PINS-1:0]   io_pin_oe,
  output logic                   regulator_inhibit_pin_out,
  output logic                   regulator_inhibit_pin_oe,
  // Block state
  output logic                   slope_select,
  output logic                   checksum_enhanced,
  output logic                   io_frames_enabled,
  output logic                   pwm_adc_reset,
  output logic                   wake_signal_req,
  output logic                   response_error,
  output logic      [5:0]        op_mode
);

  if (PINS != 8) begin : g_bad_pins
    $error("PINS must be 8: the latch fills one response byte");
  end

  typedef struct packed {
    op_mode_t        mode;
    logic [7:0]      node_address;
    logic            slope;
    logic            ecc;
    logic            sleep_uses_fallback;
    logic            inh_ext;
    logic [7:0]      fallback;
    logic [PINS-1:0] latch;
    logic [PINS-1:0] oe;
    logic            diag_pend;
    logic            resp_valid;
    logic [63:0]     resp_data;
    logic            wake_req;
    logic            pwm_rst;
    logic            inh_oe;
    logic            frames_en;
    logic            wake_prev;
    logic [31:0]     prdata;
    logic            pready;
    logic            pslverr;
  } state_t;

  state_t      st_r;
  state_t      st_nxt;
  logic        wake_sync;
  logic [7:0]  flags;
  logic [7:0]  flag_set;
  logic [7:0]  flag_clr;
  logic        req_ok;
  logic [1:0]  blk;
  logic        apb_wr;
  logic        apb_rd;

  ////////////////////////////////////////////////////////////////////////////
  // Local wake pin is asynchronous
  bit_sync2 #(.W(1)) u_wake_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in (local_wake_pin),
    .sync_out (wake_sync)
  );

  // Sticky diagnostic flags
  diag_flag_bank #(.W(8)) u_flags (
    .pclk       (pclk),
    .presetn    (presetn),
    .set_mask   (flag_set),
    .clear_mask (flag_clr),
    .flags      (flags)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Request qualification and flag events
  assign req_ok = req_valid && req_data[7:0] == st_r.node_address && req_data[23:16] == SVC_IO_CONFIG;
  assign blk    = req_data[31:30];
  assign apb_wr = psel && penable && st_r.pready && pwrite;
  assign apb_rd = psel && penable && !st_r.pready && !pwrite;

  always_comb begin
    flag_set             = '0;
    flag_set[FLG_PARITY] = parity_err;
    flag_set[FLG_RXB]    = receive_frame_fault;
    flag_set[FLG_CS]     = checksum_err;
    flag_set[FLG_TXB]    = transmit_bit_fault;
    flag_set[FLG_NVM]    = no_valid_frame_timeout;
    flag_set[FLG_LHE]    = st_nxt.mode == MODE_LIMP && st_r.mode != MODE_LIMP;
    flag_set[FLG_ERR]    = in_response &&
                           (receive_frame_fault || checksum_err || transmit_bit_fault);
    // Only the bits actually reported are cleared, later events stay
    flag_clr             = (resp_done && st_r.resp_valid) ? st_r.resp_data[39:32] : 8'h00;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic: modes, configuration, response, APB
  always_comb begin
    st_nxt          = st_r;
    st_nxt.wake_req = 1'b0;
    st_nxt.wake_prev = wake_sync;

    // Configuration request decode
    if (req_ok) begin
      if (blk == BLK_THIRD) begin
        st_nxt.slope    = req_data[24 + CFG_SLOPE_BIT];
        st_nxt.ecc      = req_data[24 + CFG_ECC_BIT];
        st_nxt.fallback = req_data[39:32];
      end
      // Read-only block, pin configuration untouched
      st_nxt.diag_pend = (blk == BLK_FOURTH);
    end

    // Diagnostic slave response
    if (resp_slot && st_r.diag_pend) begin
      st_nxt.resp_valid = 1'b1;
      st_nxt.resp_data  = {FILL_BYTE, FILL_BYTE, st_r.latch, flags,
                           DIAG_CTRL, RSP_IO_CONFIG, PCI_DIAG_RSP, st_r.node_address};
    end
    if (resp_done && st_r.resp_valid) begin
      st_nxt.resp_valid = 1'b0;
      st_nxt.diag_pend  = 1'b0;
    end

    // Address change; floating the outputs comes after the output frame decode
    if (assign_nad) begin
      st_nxt.node_address = assign_nad_value;
    end

    // Mode sequencer
    case (st_r.mode)
      MODE_CONFIG: begin
        if (bus_idle_timeout || bus_dominant_timeout || sleep_cmd) begin
          st_nxt.mode  = MODE_LIMP;
          st_nxt.latch = st_r.fallback;
        end else if (assign_nad || default_nad_used) begin
          st_nxt.mode = MODE_NORMAL;
        end
      end
      MODE_NORMAL: begin
        if (sleep_cmd) begin
          st_nxt.mode = st_r.sleep_uses_fallback ? MODE_LH_SLEEP : MODE_SLEEP;
          if (st_r.sleep_uses_fallback) begin
            st_nxt.latch = st_r.fallback;
          end
        end else if (bus_dominant_timeout) begin
          st_nxt.mode  = MODE_LIMP;
          st_nxt.latch = st_r.fallback;
        end else if (io_out_load) begin
          st_nxt.latch = io_out_value;
          st_nxt.oe    = io_out_enable;
        end
      end
      MODE_SLEEP, MODE_LH_SLEEP: begin
        // Latch untouched across wake-up
        if (wake_sync && !st_r.wake_prev) begin
          st_nxt.mode     = MODE_NORMAL;
          st_nxt.wake_req = 1'b1;
        end else if (remote_wake) begin
          st_nxt.mode = MODE_NORMAL;
        end
      end
      MODE_LIMP: begin
        if (remote_wake) begin
          st_nxt.mode = MODE_STANDBY;
        end
      end
      MODE_STANDBY: begin
        // Master acknowledges the failure by reading diagnostics
        if (resp_done && st_r.resp_valid) begin
          st_nxt.mode = MODE_NORMAL;
        end
      end
      default: begin
        st_nxt.mode = MODE_CONFIG;
      end
    endcase

    // Reconfiguration floats outputs, even against a same-cycle output frame
    if (assign_nad && st_r.mode != MODE_CONFIG) begin
      st_nxt.oe = '0;
    end

    // Low-power modes float inhibit and hold PWM/ADC in reset
    st_nxt.pwm_rst = st_nxt.mode inside {MODE_SLEEP, MODE_LH_SLEEP};
    st_nxt.frames_en = st_nxt.mode != MODE_CONFIG;
    st_nxt.inh_oe  = st_r.inh_ext &&
                     !(st_nxt.mode inside {MODE_SLEEP, MODE_LH_SLEEP, MODE_LIMP});

    // APB: one wait state, data and ready from flops
    st_nxt.pready  = psel && penable && !st_r.pready;
    st_nxt.pslverr = 1'b0;
    if (psel && penable && !st_r.pready) begin
      st_nxt.pslverr = !(paddr inside {OFF_CTRL, OFF_STATUS, OFF_FALLBACK, OFF_NODE, OFF_LATCH});
    end
    if (apb_rd) begin
      case (paddr)
        OFF_CTRL:     st_nxt.prdata = {28'h0000000, st_r.inh_ext, st_r.sleep_uses_fallback, st_r.ecc, st_r.slope};
        OFF_STATUS:   st_nxt.prdata = {16'h0000, 2'b00, st_r.mode, flags};
        OFF_FALLBACK: st_nxt.prdata = {24'h000000, st_r.fallback};
        OFF_NODE:     st_nxt.prdata = {24'h000000, st_r.node_address};
        OFF_LATCH:    st_nxt.prdata = {16'h0000, st_r.oe, st_r.latch};
        default:      st_nxt.prdata = 32'h00000000;
      endcase
    end
    // Software writes lose to a same-cycle configuration frame
    if (apb_wr && !req_ok) begin
      if (paddr == OFF_CTRL) begin
        st_nxt.slope   = pwdata[CTRL_SLOPE_BIT];
        st_nxt.ecc     = pwdata[CTRL_ECC_BIT];
        st_nxt.sleep_uses_fallback    = pwdata[CTRL_SLEEP_USES_FALLBACK_BIT];
        st_nxt.inh_ext = pwdata[CTRL_INHX_BIT];
      end else if (paddr == OFF_FALLBACK) begin
        st_nxt.fallback = pwdata[7:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register; reset gives Configuration with I/O pins floating and the inhibit pin driven
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r           <= '0;
      st_r.mode      <= MODE_CONFIG;
      st_r.node_address       <= DEFAULT_NAD;
      st_r.fallback  <= RST_FALLBACK;
      st_r.latch     <= RST_LATCH;
      st_r.inh_ext   <= 1'b1;
      st_r.inh_oe    <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from flops, except the inhibit pin level, which is tied high
  assign prdata                    = st_r.prdata;
  assign pready                    = st_r.pready;
  assign pslverr                   = st_r.pslverr;
  assign resp_valid                = st_r.resp_valid;
  assign resp_data                 = st_r.resp_data;
  assign pin_output_register       = st_r.latch;
  assign io_pin_oe                 = st_r.oe;
  assign regulator_inhibit_pin_out = 1'b1;
  assign regulator_inhibit_pin_oe  = st_r.inh_oe;
  assign slope_select              = st_r.slope;
  assign checksum_enhanced         = st_r.ecc;
  assign io_frames_enabled         = st_r.frames_en;
  assign pwm_adc_reset             = st_r.pwm_rst;
  assign wake_signal_req           = st_r.wake_req;
  assign response_error            = flags[FLG_ERR];
  assign op_mode                   = st_r.mode;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_third_block;
    req_ok && blk == BLK_THIRD |=> slope_select == $past(req_data[25]) && checksum_enhanced == $past(req_data[24]);
  endproperty
  a_third_block: assert property (p_third_block) else $error("third block not applied");

  property p_diag_resp;
    resp_slot && st_r.diag_pend && !(resp_done && st_r.resp_valid)
      |=> resp_valid && resp_data[23:0] == {RSP_IO_CONFIG, PCI_DIAG_RSP, $past(st_r.node_address)}
          && resp_data[47:40] == $past(st_r.latch);
  endproperty
  a_diag_resp: assert property (p_diag_resp) else $error("diagnostic response wrong");

  property p_parity_flag;
    parity_err |=> flags[FLG_PARITY] ##1 flags[FLG_PARITY] || $past(flag_clr[FLG_PARITY]);
  endproperty
  a_parity_flag: assert property (p_parity_flag) else $error("parity flag not set");

  property p_err_flag;
    in_response && checksum_err |=> response_error && flags[FLG_CS];
  endproperty
  a_err_flag: assert property (p_err_flag) else $error("response error not flagged");

  property p_flag_clear;
    resp_done && resp_valid && flag_set == 8'h00 |=> (flags & $past(resp_data[39:32])) == 8'h00;
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("flags not cleared after read");

  property p_config_ignores;
    op_mode == MODE_CONFIG && io_out_load |=> pin_output_register == $past(pin_output_register) || op_mode == MODE_LIMP;
  endproperty
  a_config_ignores: assert property (p_config_ignores) else $error("output frame taken in config");

  property p_config_exit;
    op_mode == MODE_CONFIG && assign_nad && !bus_idle_timeout && !bus_dominant_timeout && !sleep_cmd
      |=> op_mode == MODE_NORMAL;
  endproperty
  a_config_exit: assert property (p_config_exit) else $error("config did not reach normal");

  property p_lh_sleep;
    op_mode == MODE_NORMAL && sleep_cmd && st_r.sleep_uses_fallback
      |=> op_mode == MODE_LH_SLEEP && pin_output_register == $past(st_r.fallback) ##1 !regulator_inhibit_pin_oe;
  endproperty
  a_lh_sleep: assert property (p_lh_sleep) else $error("fallback sleep entry wrong");

  property p_limp_flag;
    $rose(op_mode == MODE_LIMP) |-> flags[FLG_LHE];
  endproperty
  a_limp_flag: assert property (p_limp_flag) else $error("limp home flag missing");

  property p_reconfig_float;
    assign_nad && op_mode != MODE_CONFIG |=> io_pin_oe == '0;
  endproperty
  a_reconfig_float: assert property (p_reconfig_float) else $error("outputs not floated");

  property p_standby_exit;
    op_mode == MODE_STANDBY && resp_done && resp_valid |=> op_mode == MODE_NORMAL
      && pin_output_register == $past(pin_output_register);
  endproperty
  a_standby_exit: assert property (p_standby_exit) else $error("standby did not exit");

  c_diag_served: cover property (resp_slot && st_r.diag_pend ##1 resp_valid ##[1:20] resp_done);
  c_lh_sleep_wake: cover property (op_mode == MODE_LH_SLEEP ##[1:50] op_mode == MODE_NORMAL);
  c_standby_normal: cover property (op_mode == MODE_STANDBY ##[1:50] op_mode == MODE_NORMAL);

endmodule : lin_slave_config_diag_modes

// ==== verif/lin_master_model.sv ====
// LIN master model: sends request frames and collects slave responses.
// Assumes the slave answers on pclk; the testbench calls the tasks.
`timescale 1ns/1ps
module lin_master_model (
  // Clock
  input  wire logic        pclk,
  // Frames to and from the slave
  output logic             req_valid,
  output logic [63:0]      req_data,
  output logic             resp_slot,
  output logic             resp_done,
  input  wire logic        resp_valid,
  input  wire logic [63:0] resp_data
);
  logic [63:0] rsp;
  ////////////////////////////////////////////////////////////
  // Idle frame lines
  initial begin
    req_valid = 1'b0;
    req_data  = 64'h0;
    resp_slot = 1'b0;
    resp_done = 1'b0;
  end
  // One request; bytes inverted after the frame so stale data never looks valid
  task send_req(input logic [63:0] d);
    @(posedge pclk);
    req_valid <= 1'b1;
    req_data  <= d;
    @(posedge pclk);
    req_valid <= 1'b0;
    req_data  <= ~d;
  endtask : send_req
  // Diagnostic request with fill bytes
  task diag_req(input logic [7:0] node_address);
    send_req({32'hffffffff, 8'hc0, 8'hb4, 8'h02, node_address});
  endtask : diag_req
  // Slot, bounded wait for the answer, then acknowledge it
  task read_resp();
    int n;
    @(posedge pclk);
    resp_slot <= 1'b1;
    @(posedge pclk);
    resp_slot <= 1'b0;
    for (n = 0; n < 20 && resp_valid !== 1'b1; n++) @(posedge pclk);
    rsp = resp_data;
    @(posedge pclk);
    resp_done <= 1'b1;
    @(posedge pclk);
    resp_done <= 1'b0;
  endtask : read_resp
endmodule : lin_master_model

// ==== verif/testbench.sv ====
// Self-checking bench for the configuration tail, diagnostics and modes.
// Assumes a 25 MHz pclk and the master model on the frame side.
`timescale 1ns/1ps
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin err_count++; \
  $display("Error %s expected %h seen %h", n, e, s); end end
module testbench;
  import lin_diag_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, in_response;
  logic [7:0] paddr, pin_output_register, io_pin_oe, fb;
  logic [31:0] pwdata, prdata, rd, r;
  logic req_valid, resp_slot, resp_done, resp_valid, inh_oe, slope, ecc, e;
  logic io_out_load, wk, wake_req, pwm_rst, resp_err, frames_en, inh_out;
  logic [7:0] io_out_value, io_out_enable, nad_v;
  logic [63:0] req_data, resp_data;
  logic [10:0] ev;
  logic [5:0]  op_mode;
  int err_count, comparisons, seed;
  ////////////////////////////////////////////////////////////
  lin_master_model lin_master_model_i (.pclk, .req_valid, .req_data, .resp_slot, .resp_done,
    .resp_valid, .resp_data);
  lin_slave_config_diag_modes lin_slave_config_diag_modes_i (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .req_valid, .req_data, .resp_slot,
    .resp_done, .resp_valid, .resp_data, .parity_err(ev[0]), .receive_frame_fault(ev[1]),
    .checksum_err(ev[2]), .transmit_bit_fault(ev[3]), .in_response, .no_valid_frame_timeout(ev[4]),
    .bus_idle_timeout(ev[5]), .bus_dominant_timeout(ev[6]), .sleep_cmd(ev[7]), .remote_wake(ev[8]),
    .assign_nad(ev[10]), .assign_nad_value(nad_v), .default_nad_used(ev[9]), .io_out_load,
    .io_out_value, .io_out_enable, .local_wake_pin(wk), .pin_output_register,
    .io_pin_oe, .regulator_inhibit_pin_out(inh_out), .regulator_inhibit_pin_oe(inh_oe),
    .slope_select(slope), .checksum_enhanced(ecc), .io_frames_enabled(frames_en), .pwm_adc_reset(pwm_rst),
    .wake_signal_req(wake_req), .response_error(resp_err), .op_mode);
  ////////////////////////////////////////////////////////////
  // Clock and watchdog
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  initial begin
    repeat (5000) @(posedge pclk);
    err_count++;
    finish_test();
  end
  task finish_test();
    if (err_count == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : finish_test
  // APB read; waits for pready under a bound
  task apb_rd(input logic [7:0] a);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= 1'b0;
    paddr   <= a;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) err_count++;
    rd = prdata;
    e  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb_rd
  // One-cycle event pulse, then let the result settle
  task pulse(input logic [10:0] m);
    @(posedge pclk);
    ev <= m;
    @(posedge pclk);
    ev <= 11'h0;
    #1;
  endtask : pulse
  // APB write; request held until pready is sampled high
  task apb_wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= 1'b1;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) err_count++;
    psel    <= 1'b0;
    penable <= 1'b0;
    pwrite  <= 1'b0;
  endtask : apb_wr
  // One output frame with value and enables
  task load_out(input logic [7:0] v, input logic [7:0] en);
    @(posedge pclk);
    io_out_load   <= 1'b1;
    io_out_value  <= v;
    io_out_enable <= en;
    @(posedge pclk);
    io_out_load   <= 1'b0;
    #1;
  endtask : load_out
  // Reset in mid-run, two edges long
  task rst();
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    #1;
  endtask : rst
  ////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    {psel, penable, pwrite, in_response, presetn} = 5'h0;
    {paddr, pwdata, ev, io_out_load, io_out_value, io_out_enable, wk} = '0;
    seed = 32'hf0d0;
    r = $random(seed);
    nad_v = {1'b0, r[6:0]};
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    #1;
    `CHK("mode", MODE_CONFIG, op_mode)
    `CHK("oe", 8'h00, io_pin_oe)
    `CHK("inh", 1'b1, inh_oe)
    `CHK("inhout", 1'b1, inh_out)
    `CHK("fren", 1'b0, frames_en)
    // Output frame refused in Configuration
    load_out(8'ha5, 8'hff);
    `CHK("cfgoe", 8'h00, io_pin_oe)
    `CHK("cfglat", 8'h00, pin_output_register)
    apb_rd(8'h40);
    `CHK("slverr", 1'b1, e)
    lin_master_model_i.send_req(64'hffff00ff_83b5047f);
    #1;
    `CHK("badsvc", 1'b0, slope)
    // Third block, every slope and checksum pairing
    for (int i = 0; i < 4; i++) begin
      r  = $random(seed);
      fb = r[7:0];
      lin_master_model_i.send_req({16'hffff, 8'h00, fb, 6'b100000, i[1:0], 16'hb404, 8'h7f});
      #1;
      `CHK("slope", i[1], slope)
      `CHK("ecc", i[0], ecc)
    end
    apb_rd(OFF_FALLBACK);
    `CHK("fallback", fb, rd[7:0])
    // Errors while in a response frame, then diagnostic read-out
    in_response <= 1'b1;
    pulse(11'h01f);
    `CHK("resperr", 1'b1, resp_err)
    in_response <= 1'b0;
    lin_master_model_i.diag_req(8'h7f);
    lin_master_model_i.read_resp();
    #1;
    `CHK("diag", 64'hffff00f5_c0f4047f, lin_master_model_i.rsp)
    apb_rd(OFF_STATUS);
    `CHK("cleared", 8'h00, rd[7:0])
    // Dominant timeout, standby, acknowledge
    pulse(11'h040);
    `CHK("limp", MODE_LIMP, op_mode)
    pulse(11'h100);
    `CHK("standby", MODE_STANDBY, op_mode)
    lin_master_model_i.diag_req(8'h7f);
    lin_master_model_i.read_resp();
    #1;
    `CHK("diag2", {16'hffff, fb, 40'h02c0f4047f}, lin_master_model_i.rsp)
    `CHK("normal", MODE_NORMAL, op_mode)
    `CHK("fren1", 1'b1, frames_en)
    `CHK("keep", fb, pin_output_register)
    // Sleep then remote wake
    pulse(11'h080);
    `CHK("sleep", MODE_SLEEP, op_mode)
    `CHK("inhslp", 1'b0, inh_oe)
    pulse(11'h100);
    `CHK("wake", MODE_NORMAL, op_mode)
    `CHK("inhwk", 1'b1, inh_oe)
    `CHK("latch", fb, pin_output_register)
    // Fallback sleep, then local wake-up
    apb_wr(OFF_CTRL, 32'h0000000c);
    apb_rd(OFF_CTRL);
    `CHK("ctrl", 4'hc, rd[3:0])
    load_out(~fb, 8'hff);
    `CHK("outld", ~fb, pin_output_register)
    pulse(11'h080);
    `CHK("lhslp", MODE_LH_SLEEP, op_mode)
    `CHK("lhval", fb, pin_output_register)
    `CHK("pwm", 1'b1, pwm_rst)
    @(posedge pclk);
    wk <= 1'b1;
    repeat (3) @(posedge pclk);
    #1;
    `CHK("wkreq", 1'b1, wake_req)
    `CHK("lhwake", MODE_NORMAL, op_mode)
    `CHK("lhkeep", fb, pin_output_register)
    // Mid-run reset; default address use, then reconfiguration floats outputs
    rst();
    `CHK("rst2", MODE_CONFIG, op_mode)
    `CHK("rstlat", 8'h00, pin_output_register)
    pulse(11'h200);
    `CHK("dflt", MODE_NORMAL, op_mode)
    load_out(fb, 8'hff);
    `CHK("oeld", 8'hff, io_pin_oe)
    pulse(11'h400);
    `CHK("float", 8'h00, io_pin_oe)
    // Address assignment leaves Configuration
    rst();
    pulse(11'h400);
    `CHK("asgn", MODE_NORMAL, op_mode)
    apb_rd(OFF_NODE);
    `CHK("node", nad_v, rd[7:0])
    finish_test();
  end
endmodule : testbench
